// >>> energy_pulse_frequency_scaler.sv
`timescale 1ns/10ps

// Behaviour
// - Low-rate rate is power times base frequency
// - Full-scale ac gives 0.204 of base frequency
// - Half-scale inputs give 0.051 of base frequency
// - Calibration output uses same power, shorter accumulation
// - Scale select high: ratios 128, 64, 32, 16
// - Scale select low: ratios 64, 32, 16
// - Scale low, both selects high: ratio 2048
// - Calibration peaks 22.4 Hz, 11.2 Hz, 2.867 kHz
// - Frequency selects pick one of four bases
// - Base is oscillator over two to 19..16
// - Low-rate outputs pulse active low
// - Low-rate outputs alternate between A and B
// - Calibration pulses active high, 90 ms wide and at most half the period (fixed 35 us in high-frequency mode, not limited by the period)
module energy_pulse_frequency_scaler #(
    parameter int OSC_DIV       = pulse_scaler_pkg::CLK_HZ / pulse_scaler_pkg::OSC_HZ,
    parameter int CAL_WIDTH_CYC = pulse_scaler_pkg::CAL_WIDTH_MS * (pulse_scaler_pkg::CLK_HZ / 1000),
    parameter int LOW_WIDTH_CYC = pulse_scaler_pkg::LOW_WIDTH_MS * (pulse_scaler_pkg::CLK_HZ / 1000)
) (
    // Clock and reset
    input  wire logic                                   ref_clk,
    input  wire logic                                   arst_n,
    // Filtered power product, same clock domain
    input  wire logic [pulse_scaler_pkg::POWER_W-1:0]   powerLevel,
    // Static selection pins, asynchronous
    input  wire pulse_scaler_pkg::sel_t                 selPins,
    // Pulse outputs
    output pulse_scaler_pkg::pulses_t                   pulses
);
    import pulse_scaler_pkg::*;

    localparam int ACC_W = POWER_W + BASE_SHIFT + 1;
    localparam int CNT_W = 32;

    // ======================================================================
    // Helpers
    // ======================================================================
    // Shorter of the nominal width and half the last period
    function automatic logic [CNT_W-1:0] pulseWidth(input logic [CNT_W-1:0] period,
                                                    input logic [CNT_W-1:0] nominal);
        logic [CNT_W-1:0] half;
        half = period >> 1;
        if (half == '0)
            half = 32'h0000_0001;
        pulseWidth = (half < nominal) ? half : nominal;
    endfunction : pulseWidth

    function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] v);
        satInc = (v == '1) ? v : v + 32'h0000_0001;
    endfunction : satInc

    // ======================================================================
    // Select synchroniser
    // ======================================================================
    sel_t selMeta_reg;
    sel_t sel_reg;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            selMeta_reg <= SEL_RESET;
            sel_reg     <= SEL_RESET;
        end
        else
        begin
            selMeta_reg <= selPins;
            sel_reg     <= selMeta_reg;
        end
    end

    // ======================================================================
    // Thresholds
    // ======================================================================
    logic [1:0] freqCode;
    logic       highFreqMode;
    logic [4:0] lowShift;
    logic [4:0] calLog2;
    logic [4:0] calShift;
    logic [ACC_W-1:0] lowThr;
    logic [ACC_W-1:0] calThr;

    always_comb
    begin
        freqCode     = {sel_reg.freqSelectHi, sel_reg.freqSelectLo};
        highFreqMode = !sel_reg.calScaleSelect && (freqCode == 2'h3);
        lowShift     = 5'(BASE_SHIFT) - {3'h0, freqCode};
        if (highFreqMode)
            calLog2 = 5'(HF_CAL_LOG2);
        else if (sel_reg.calScaleSelect)
            calLog2 = 5'(SCALE_HI_LOG2) - {3'h0, freqCode};
        else
            calLog2 = 5'(SCALE_LO_LOG2) - {3'h0, freqCode};
        calShift = lowShift - calLog2;
        // Shift amounts reach 35, so they are summed at six bits to avoid wrapping
        lowThr   = ACC_W'(1) << (6'(lowShift) + 6'(POWER_W));
        calThr   = ACC_W'(1) << (6'(calShift) + 6'(POWER_W));
    end

    // ======================================================================
    // Oscillator tick
    // ======================================================================
    // The accumulators advance at the internal oscillator rate, so every
    // output rate scales with it exactly as the base frequencies do.
    logic [CNT_W-1:0] oscCnt_reg;
    logic             oscTick;

    assign oscTick = (oscCnt_reg == CNT_W'(OSC_DIV - 1));

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            oscCnt_reg <= '0;
        else if (oscTick)
            oscCnt_reg <= '0;
        else
            oscCnt_reg <= oscCnt_reg + 32'h0000_0001;
    end

    // ======================================================================
    // Accumulators
    // ======================================================================
    // Remainder is kept on each crossing so no energy is lost between
    // pulses; a threshold change from the pins takes effect next tick.
    logic [ACC_W-1:0] lowAcc_reg;
    logic [ACC_W-1:0] calAcc_reg;
    logic [ACC_W-1:0] lowSum;
    logic [ACC_W-1:0] calSum;
    logic             lowFire;
    logic             calFire;

    assign lowSum  = lowAcc_reg + ACC_W'(powerLevel);
    assign calSum  = calAcc_reg + ACC_W'(powerLevel);
    assign lowFire = oscTick && (lowSum >= lowThr);
    assign calFire = oscTick && (calSum >= calThr);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            lowAcc_reg <= '0;
        else if (oscTick)
            lowAcc_reg <= lowFire ? lowSum - lowThr : lowSum;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            calAcc_reg <= '0;
        else if (oscTick)
            calAcc_reg <= calFire ? calSum - calThr : calSum;
    end

    // ======================================================================
    // Period measurement
    // ======================================================================
    logic [CNT_W-1:0] lowPeriodCnt_reg;
    logic [CNT_W-1:0] calPeriodCnt_reg;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lowPeriodCnt_reg <= '1;
            calPeriodCnt_reg <= '1;
        end
        else
        begin
            lowPeriodCnt_reg <= lowFire ? 32'h0000_0001 : satInc(lowPeriodCnt_reg);
            calPeriodCnt_reg <= calFire ? 32'h0000_0001 : satInc(calPeriodCnt_reg);
        end
    end

    // ======================================================================
    // Low-rate pulse pair
    // ======================================================================
    logic             phaseB_reg;
    logic [CNT_W-1:0] lowWidthCnt_reg;
    logic             pulseA_reg;
    logic             pulseB_reg;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phaseB_reg      <= 1'b0;
            lowWidthCnt_reg <= '0;
            pulseA_reg      <= 1'b0;
            pulseB_reg      <= 1'b0;
        end
        else if (lowFire)
        begin
            // A new crossing cuts any pulse still running on the other side
            phaseB_reg      <= !phaseB_reg;
            pulseA_reg      <= !phaseB_reg;
            pulseB_reg      <= phaseB_reg;
            lowWidthCnt_reg <= pulseWidth(lowPeriodCnt_reg, CNT_W'(LOW_WIDTH_CYC));
        end
        else if (lowWidthCnt_reg > 32'h0000_0001)
            lowWidthCnt_reg <= lowWidthCnt_reg - 32'h0000_0001;
        else
        begin
            lowWidthCnt_reg <= '0;
            pulseA_reg      <= 1'b0;
            pulseB_reg      <= 1'b0;
        end
    end

    // ======================================================================
    // Calibration pulse
    // ======================================================================
    logic [CNT_W-1:0] calWidthCnt_reg;
    logic             calPulse_reg;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            calWidthCnt_reg <= '0;
            calPulse_reg    <= 1'b0;
        end
        else if (calFire)
        begin
            calPulse_reg <= 1'b1;
            if (highFreqMode)
                calWidthCnt_reg <= CNT_W'(HF_WIDTH_CYC);
            else
                calWidthCnt_reg <= pulseWidth(calPeriodCnt_reg, CNT_W'(CAL_WIDTH_CYC));
        end
        else if (calWidthCnt_reg > 32'h0000_0001)
            calWidthCnt_reg <= calWidthCnt_reg - 32'h0000_0001;
        else
        begin
            calWidthCnt_reg <= '0;
            calPulse_reg    <= 1'b0;
        end
    end

    // Active-low drive of the low-rate pair
    assign pulses.lowRatePulseA_n = !pulseA_reg;
    assign pulses.lowRatePulseB_n = !pulseB_reg;
    assign pulses.calPulseOut     = calPulse_reg;

endmodule : energy_pulse_frequency_scaler

// >>> energy_pulse_frequency_scaler_tb.sv
`timescale 1ns/10ps
// ==========
// Bench top
module energy_pulse_frequency_scaler_tb;
    import pulse_scaler_pkg::*;
    localparam int OSC_DIV = 1;
    localparam int CAL_W   = 50;
    localparam int LOW_W   = 100;
    logic               ref_clk    = 1'b0;
    logic               arst_n     = 1'b0;
    logic [POWER_W-1:0] powerLevel = '0;
    sel_t               selPins    = SEL_RESET;
    pulses_t            pulses;
    int                 calCount;
    int                 n_mismatch = 0;
    int                 n_checks   = 0;
    always #5 ref_clk = ~ref_clk;
    energy_pulse_frequency_scaler #(.OSC_DIV(OSC_DIV), .CAL_WIDTH_CYC(CAL_W), .LOW_WIDTH_CYC(LOW_W)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .powerLevel(powerLevel), .selPins(selPins), .pulses(pulses));
    pulse_counter_model partner (.ref_clk(ref_clk), .arst_n(arst_n), .pulses(pulses), .calCount(calCount));
    task automatic check_range(input string what, input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s got %0d want %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : check_range
    task automatic check_pulses(input pulses_t got);
        n_checks++;
        if (got !== PULSE_IDLE)
        begin
            n_mismatch++;
            $display("[ERR] %0t outputs %b not idle", $time, got);
        end
    endtask : check_pulses
    // Ratio of cal rate to low rate, worked out per select code
    function automatic int cal_ratio(input sel_t s, input int code);
        if (s.calScaleSelect)
            return 128 >> code;
        return (code == 3) ? 2048 : 64 >> code;
    endfunction : cal_ratio
    task automatic run_mode(input sel_t s, input logic [POWER_W-1:0] p, input int wantW);
        int     code;
        longint thr;
        int     ticks;
        int     cyc;
        int     wid;
        code  = {s.freqSelectHi, s.freqSelectLo};
        thr   = (longint'(1) << (POWER_W + BASE_SHIFT - code)) / cal_ratio(s, code);
        ticks = int'((thr + p - 1) / p);
        cyc   = 0;
        wid   = 0;
        @(negedge ref_clk);
        arst_n     = 1'b0;
        selPins    = s;
        powerLevel = p;
        repeat (3) @(negedge ref_clk);
        check_pulses(pulses);
        arst_n = 1'b1;
        while (calCount == 0 && cyc < 40000)
        begin
            @(negedge ref_clk);
            cyc++;
        end
        check_range("first cal", cyc, ticks * OSC_DIV - 6, ticks * OSC_DIV + 6);
        while (pulses.calPulseOut === 1'b1 && wid < 5000)
        begin
            @(negedge ref_clk);
            wid++;
        end
        check_range("cal width", wid + 1, wantW - 2, wantW + 2);
    endtask : run_mode
    task automatic test_scale_high();
        for (int c = 0; c < 4; c++)
            run_mode(sel_t'({1'b1, 2'(c)}), 16'hFFFF, CAL_W);
        $display("test_scale_high done");
    endtask : test_scale_high
    // Runs on from the last scale-high run (code 3, full power) with no reset:
    // the 16th cal crossing and the first low crossing fall on one tick
    task automatic test_low_pair();
        int cyc;
        int wid;
        cyc = 0;
        wid = 0;
        while (pulses.lowRatePulseA_n !== 1'b0 && cyc < 70000)
        begin
            @(negedge ref_clk);
            cyc++;
        end
        @(negedge ref_clk);
        check_range("cal per low", calCount, 16, 16);
        check_range("B idle", int'(pulses.lowRatePulseB_n), 1, 1);
        while (pulses.lowRatePulseA_n === 1'b0 && wid < 5000)
        begin
            @(negedge ref_clk);
            wid++;
        end
        check_range("low width", wid + 1, LOW_W - 2, LOW_W + 2);
        $display("test_low_pair done");
    endtask : test_low_pair
    task automatic test_scale_low();
        for (int c = 0; c < 3; c++)
            run_mode(sel_t'({1'b0, 2'(c)}), 16'hFFFF, CAL_W);
        $display("test_scale_low done");
    endtask : test_scale_low
    task automatic test_high_freq();
        run_mode(sel_t'(3'h3), 16'h0200, HF_WIDTH_CYC);
        $display("test_high_freq done");
    endtask : test_high_freq
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (10) @(negedge ref_clk);
        arst_n = 1'b1;
        test_scale_high();
        test_low_pair();
        test_scale_low();
        test_high_freq();
        end_sim();
    end
    // Whole run needs about 111k cycles, most of it waiting for one low-rate pulse
    initial
    begin
        repeat (130000) @(posedge ref_clk);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
endmodule : energy_pulse_frequency_scaler_tb
bind energy_pulse_frequency_scaler pulse_scaler_chk #(.OSC_DIV(OSC_DIV), .CAL_WIDTH_CYC(CAL_WIDTH_CYC),
    .LOW_WIDTH_CYC(LOW_WIDTH_CYC)) chk (.ref_clk(ref_clk), .arst_n(arst_n), .powerLevel(powerLevel), .pulses(pulses));

// >>> pulse_counter_model.sv
`timescale 1ns/10ps
// ==========
// Far-side pulse counter
module pulse_counter_model (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    // Pulses in, count out
    input  wire pulse_scaler_pkg::pulses_t pulses,
    output int                             calCount
);
    import pulse_scaler_pkg::*;
    logic calSeen_reg;
    // Counts edges only; the reader divides by its own interval
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
        begin
            calCount    <= 0;
            calSeen_reg <= 1'b0;
        end
        else
        begin
            calSeen_reg <= pulses.calPulseOut;
            if (pulses.calPulseOut && !calSeen_reg)
                calCount <= calCount + 1;
        end
endmodule : pulse_counter_model

// >>> pulse_scaler_chk.sv
`timescale 1ns/10ps
// ==========
// Port checker
module pulse_scaler_chk #(
    parameter int OSC_DIV       = 2,
    parameter int CAL_WIDTH_CYC = 50,
    parameter int LOW_WIDTH_CYC = 100
) (
    // Clock, reset, input
    input wire logic                                 ref_clk,
    input wire logic                                 arst_n,
    input wire logic [pulse_scaler_pkg::POWER_W-1:0] powerLevel,
    // Outputs
    input wire pulse_scaler_pkg::pulses_t            pulses
);
    import pulse_scaler_pkg::*;
    localparam int CAL_MAX = (CAL_WIDTH_CYC > HF_WIDTH_CYC) ? CAL_WIDTH_CYC : HF_WIDTH_CYC;
    int   calRun_reg;
    int   lowRun_reg;
    logic lastA_reg;
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            calRun_reg <= 0;
        else
            calRun_reg <= pulses.calPulseOut ? calRun_reg + 1 : 0;
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            lowRun_reg <= 0;
        else
            lowRun_reg <= !pulses.lowRatePulseA_n ? lowRun_reg + 1 : 0;
    // Out of reset B counts as the last one, so A may lead
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            lastA_reg <= 1'b0;
        else if ($fell(pulses.lowRatePulseA_n))
            lastA_reg <= 1'b1;
        else if ($fell(pulses.lowRatePulseB_n))
            lastA_reg <= 1'b0;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_idle_after_reset: assert property ($rose(arst_n) |-> pulses == PULSE_IDLE)
        else $error("outputs not idle after reset");
    a_cal_quiet_start: assert property ($rose(arst_n) |-> !pulses.calPulseOut [*8])
        else $error("cal pulse too soon after reset");
    a_low_not_both: assert property (pulses.lowRatePulseA_n || pulses.lowRatePulseB_n)
        else $error("both low-rate outputs active");
    a_low_alternate: assert property ($fell(pulses.lowRatePulseA_n) |-> !lastA_reg)
        else $error("output A pulsed twice in a row");
    a_cal_width_max: assert property (calRun_reg <= CAL_MAX)
        else $error("cal pulse too long");
    a_low_width_max: assert property (lowRun_reg <= LOW_WIDTH_CYC)
        else $error("low-rate pulse too long");
    a_cal_min_width: assert property ($rose(pulses.calPulseOut) |-> pulses.calPulseOut [*8])
        else $error("cal pulse too short");
    a_cal_needs_power: assert property ($rose(pulses.calPulseOut) |->
        ($past(powerLevel) != 0 || $past(powerLevel, 2) != 0))
        else $error("cal pulse without power");
endmodule : pulse_scaler_chk

// >>> pulse_scaler_pkg.sv
package pulse_scaler_pkg;

    // ======================================================================
    // Widths and oscillator
    // ======================================================================
    localparam int POWER_W     = 16;
    localparam int CLK_HZ      = 100_000_000;
    localparam int OSC_HZ      = 450_000;
    localparam int BASE_SHIFT  = 19;
    localparam int HF_CAL_LOG2 = 11;
    localparam int SCALE_HI_LOG2 = 7;
    localparam int SCALE_LO_LOG2 = 6;

    // ======================================================================
    // Pulse timing
    // ======================================================================
    localparam int CAL_WIDTH_MS = 90;
    localparam int LOW_WIDTH_MS = 240;
    localparam int HF_WIDTH_US  = 35;
    localparam int HF_WIDTH_CYC = (HF_WIDTH_US * (CLK_HZ / 1_000_000) > 0) ?
                                  HF_WIDTH_US * (CLK_HZ / 1_000_000) : 1;

    // ======================================================================
    // Carriers
    // ======================================================================
    typedef struct packed {
        logic calScaleSelect;
        logic freqSelectHi;
        logic freqSelectLo;
    } sel_t;

    typedef struct packed {
        logic lowRatePulseA_n;
        logic lowRatePulseB_n;
        logic calPulseOut;
    } pulses_t;

    localparam sel_t    SEL_RESET   = 3'h0;
    localparam pulses_t PULSE_IDLE  = 3'h6;

endpackage : pulse_scaler_pkg
